// file: verilog/io_status_segment_monitor.sv
`timescale 1ns/10ps
`include "status_monitor_defs.svh"
//
// Behaviour
// - mode key enters monitor number display
// - up/down keys step through three monitors
// - one-second shift hold shows status pattern
// - one-second shift hold returns to number
// - input off lights top, on lights bottom
// - output off lights top, on lights bottom
// - safety inputs use inverted segment polarity
// - input positions one to eight mapping
// - output positions one to seven, eight reserved
// - safety positions one and two, rest reserved
// - shorted input terminal counts as on
// - conducting output transistor counts as on
module io_status_segment_monitor #(
  parameter int HOLD_CYCLES = `HOLD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        mode_key,
  input  wire logic        up_key,
  input  wire logic        down_key,
  input  wire logic        shift_key,
  input  wire logic        servo_on_shorted,
  input  wire logic        proportional_control_input,
  input  wire logic        forward_overtravel_input,
  input  wire logic        reverse_overtravel_input,
  input  wire logic        alarm_reset_input,
  input  wire logic        forward_current_limit_input,
  input  wire logic        reverse_current_limit_input,
  input  wire logic        sensor_on_input,
  input  wire logic        alarm_output,
  input  wire logic        positioning_complete_output,
  input  wire logic        rotation_detect_output,
  input  wire logic        servo_ready_output,
  input  wire logic        alarm_code_bit_one,
  input  wire logic        alarm_code_bit_two,
  input  wire logic        alarm_code_bit_three,
  input  wire logic        hard_block_input_one,
  input  wire logic        hard_block_input_two,
  output logic [1:0]       panel_mode,
  output logic [11:0]      monitor_number,
  output logic [55:0]      segments
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronise keys and input terminal states

  localparam int NKEY = 4;
  localparam int NIN  = 10;

  logic [NKEY-1:0] keys;
  logic [NIN-1:0]  in_sync;

  key_sync #(.WIDTH(NKEY)) u_key_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({shift_key, down_key, up_key, mode_key}),
    .sync_out (keys)
  );

  key_sync #(.WIDTH(NIN)) u_in_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({hard_block_input_two, hard_block_input_one,
                sensor_on_input, reverse_current_limit_input,
                forward_current_limit_input, alarm_reset_input,
                reverse_overtravel_input, forward_overtravel_input,
                proportional_control_input, servo_on_shorted}),
    .sync_out (in_sync)
  );

  // outputs come from logic on the same clock and need no synchroniser
  wire [6:0] out_on = {alarm_code_bit_three, alarm_code_bit_two, alarm_code_bit_one,
                       servo_ready_output, rotation_detect_output,
                       positioning_complete_output, alarm_output};

  ////////////////////////////////////////////////////////////////////////////
  // key edges and shift hold timer

  logic [NKEY-1:0] keys_q;
  logic [31:0]     hold_count;
  logic            hold_done;

  wire mode_press  = keys[0] & ~keys_q[0];
  wire up_press    = keys[1] & ~keys_q[1];
  wire down_press  = keys[2] & ~keys_q[2];
  // timer restarts whenever shift is released, so one toggle per hold
  wire hold_reach  = keys[3] && !hold_done && (hold_count == 32'(HOLD_CYCLES - 1));
  wire [31:0] next_hold_count = keys[3] ? (hold_reach ? hold_count : hold_count + 32'h1)
                                        : 32'h0;
  wire next_hold_done = keys[3] & (hold_done | hold_reach);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keys_q     <= '0;
      hold_count <= 32'h0;
      hold_done  <= 1'b0;
    end else begin
      keys_q     <= keys;
      hold_count <= next_hold_count;
      hold_done  <= next_hold_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // panel mode and monitor selection

  status_monitor_pkg::panel_mode_t  mode;
  status_monitor_pkg::panel_mode_t  next_mode;
  status_monitor_pkg::monitor_sel_t sel;
  status_monitor_pkg::monitor_sel_t next_sel;

  always_comb begin
    next_mode = mode;
    next_sel  = sel;
    unique case (mode)
      status_monitor_pkg::panel_status: begin
        if (mode_press)
          next_mode = status_monitor_pkg::panel_number;
      end
      status_monitor_pkg::panel_number: begin
        // mode key wins over a finished hold, a finished hold over stepping
        if (mode_press)
          next_mode = status_monitor_pkg::panel_status;
        else if (hold_reach)
          next_mode = status_monitor_pkg::panel_pattern;
        else if (up_press) begin
          unique case (sel)
            status_monitor_pkg::mon_input:  next_sel = status_monitor_pkg::mon_output;
            status_monitor_pkg::mon_output: next_sel = status_monitor_pkg::mon_safety;
            default:                        next_sel = status_monitor_pkg::mon_input;
          endcase
        end else if (down_press) begin
          unique case (sel)
            status_monitor_pkg::mon_input:  next_sel = status_monitor_pkg::mon_safety;
            status_monitor_pkg::mon_output: next_sel = status_monitor_pkg::mon_input;
            default:                        next_sel = status_monitor_pkg::mon_output;
          endcase
        end
      end
      status_monitor_pkg::panel_pattern: begin
        if (hold_reach)
          next_mode = status_monitor_pkg::panel_number;
      end
      default: next_mode = status_monitor_pkg::panel_status;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= status_monitor_pkg::panel_status;
      sel  <= status_monitor_pkg::mon_input;
    end else begin
      mode <= next_mode;
      sel  <= next_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // segment pattern

  logic [7:0] on_bits;
  logic [7:0] valid_bits;
  logic       inverted;

  always_comb begin
    unique case (sel)
      status_monitor_pkg::mon_output: begin
        on_bits    = {1'b0, out_on};
        valid_bits = 8'h7f;
        inverted   = 1'b0;
      end
      status_monitor_pkg::mon_safety: begin
        on_bits    = {6'h00, in_sync[9:8]};
        valid_bits = 8'h03;
        inverted   = 1'b1;
      end
      default: begin
        on_bits    = in_sync[7:0];
        valid_bits = 8'hff;
        inverted   = 1'b0;
      end
    endcase
  end

  logic [55:0] pattern;

  always_comb begin
    pattern = 56'h0;
    for (int i = 0; i < `POSITIONS; i++) begin
      if (valid_bits[i]) begin
        if (on_bits[i] ^ inverted)
          pattern[i*`SEG_WIDTH + `SEG_BOTTOM] = 1'b1;
        else
          pattern[i*`SEG_WIDTH + `SEG_TOP] = 1'b1;
      end
    end
  end

  wire [11:0] next_monitor_number = (sel == status_monitor_pkg::mon_output) ? `MON_NUM_OUTPUT :
                                    (sel == status_monitor_pkg::mon_safety) ? `MON_NUM_SAFETY :
                                    `MON_NUM_INPUT;
  wire [55:0] next_segments = (mode == status_monitor_pkg::panel_pattern) ? pattern : 56'h0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      monitor_number <= 12'h000;
      segments       <= 56'h0;
    end else begin
      monitor_number <= next_monitor_number;
      segments       <= next_segments;
    end
  end

  assign panel_mode = mode;

endmodule

// file: pkg/status_monitor_defs.svh
`ifndef STATUS_MONITOR_DEFS_SVH
`define STATUS_MONITOR_DEFS_SVH

// clock rate and key hold time
`define CLK_FREQ_HZ        10000000
`define HOLD_TIME_MS       1000
`define HOLD_CYCLES        ((`CLK_FREQ_HZ / 1000) * `HOLD_TIME_MS)

// monitor numbers shown in number mode
`define MON_NUM_INPUT      12'h005
`define MON_NUM_OUTPUT     12'h006
`define MON_NUM_SAFETY     12'h015

// segment field positions within one display position
`define SEG_TOP            0
`define SEG_BOTTOM         3
`define SEG_WIDTH          7
`define POSITIONS          8

`endif

// file: pkg/status_monitor_pkg.sv
package status_monitor_pkg;

  typedef enum logic [1:0] {
    mon_input,
    mon_output,
    mon_safety
  } monitor_sel_t;

  typedef enum logic [1:0] {
    panel_status,
    panel_number,
    panel_pattern
  } panel_mode_t;

endpackage

// file: verilog/key_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser with agreement of the last two stages
module key_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire  [WIDTH-1:0] next_sync_out = (agree & stage3) | (~agree & sync_out);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule

// file: tb/io_status_segment_monitor_checker.sv
`timescale 1ns/10ps
module io_status_segment_monitor_checker #(
  parameter int HOLD_CYCLES = 8
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        alarm_output,
  input wire logic [1:0]  panel_mode,
  input wire logic [11:0] monitor_number,
  input wire logic [55:0] segments
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [1:0] prev_mode;
  logic       steady;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_mode <= 2'h0;
    end else begin
      prev_mode <= panel_mode;
    end
  end
  assign steady = panel_mode == 2'h2 && prev_mode == 2'h2;
  ////////////////////////////////////////////////////////////
  a_mode_legal: assert property (panel_mode != 2'h3)
    else $error("panel mode out of range");
  a_number_legal: assert property (panel_mode == 2'h1 |->
    monitor_number inside {12'h005, 12'h006, 12'h015}) else $error("bad monitor number");
  a_pattern_entry: assert property (panel_mode == 2'h2 && prev_mode != 2'h2 |->
    prev_mode == 2'h1) else $error("pattern entered not from number");
  a_pattern_exit: assert property (panel_mode != 2'h2 && prev_mode == 2'h2 |->
    panel_mode == 2'h1) else $error("pattern left not to number");
  a_blank_outside: assert property (panel_mode != 2'h2 && prev_mode != 2'h2 |->
    segments == 56'h0) else $error("segments lit outside pattern");
  a_one_segment: assert property (steady |-> segments[0] != segments[3])
    else $error("position one not single segment");
  a_alarm_value: assert property (steady && monitor_number == 12'h006 |->
    segments[3] == $past(alarm_output) && segments[0] == !$past(alarm_output))
    else $error("alarm position wrong");
  a_output_spare: assert property (steady && monitor_number == 12'h006 |->
    segments[55:49] == 7'h0) else $error("reserved output position lit");
  a_safety_spare: assert property (steady && monitor_number == 12'h015 |->
    segments[55:14] == 42'h0) else $error("reserved safety position lit");
  a_number_held: assert property (steady |-> $stable(monitor_number))
    else $error("number changed in pattern");
endmodule
bind io_status_segment_monitor io_status_segment_monitor_checker #(
  .HOLD_CYCLES(HOLD_CYCLES)) chk (.clk(clk), .rst_b(rst_b), .alarm_output(alarm_output),
  .panel_mode(panel_mode), .monitor_number(monitor_number), .segments(segments));

// file: tb/io_panel_partner.sv
`timescale 1ns/10ps
module io_panel_partner (
  input  wire logic       clk,
  output logic      [3:0] keys,
  output logic      [7:0] in_t,
  output logic      [6:0] out_t,
  output logic      [1:0] hb
);
  // keys: 0 mode, 1 up, 2 down, 3 shift
  initial begin
    keys = 4'h0;
    in_t = 8'h00;
    out_t = 7'h00;
    hb = 2'h0;
  end
  task automatic push(input int k, input int n);
    @(posedge clk) keys <= 4'(1 << k);
    repeat (n) @(posedge clk);
    keys <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
  // high level means shorted terminal or conducting transistor
  task automatic set_io(input logic [7:0] v);
    @(posedge clk);
    in_t <= v;
    out_t <= v[6:0];
    hb <= v[1:0];
  endtask
endmodule

// file: tb/io_status_segment_monitor_tb.sv
`timescale 1ns/10ps
module io_status_segment_monitor_tb;
  localparam int HOLD = 8;
  localparam logic [11:0] seq [6] = '{12'h006, 12'h015, 12'h005, 12'h015, 12'h006, 12'h005};
  logic        clk;
  logic        rst_b;
  logic [3:0]  keys;
  logic [7:0]  in_t;
  logic [6:0]  out_t;
  logic [1:0]  hb;
  logic [1:0]  panel_mode;
  logic [11:0] monitor_number;
  logic [55:0] segments;
  int          failures;
  int          comparisons;
  io_panel_partner op (.clk(clk), .keys(keys), .in_t(in_t), .out_t(out_t), .hb(hb));
  io_status_segment_monitor #(.HOLD_CYCLES(HOLD)) dut (
    .clk(clk), .rst_b(rst_b), .mode_key(keys[0]), .up_key(keys[1]),
    .down_key(keys[2]), .shift_key(keys[3]), .servo_on_shorted(in_t[0]),
    .proportional_control_input(in_t[1]), .forward_overtravel_input(in_t[2]),
    .reverse_overtravel_input(in_t[3]), .alarm_reset_input(in_t[4]),
    .forward_current_limit_input(in_t[5]), .reverse_current_limit_input(in_t[6]),
    .sensor_on_input(in_t[7]), .alarm_output(out_t[0]),
    .positioning_complete_output(out_t[1]), .rotation_detect_output(out_t[2]),
    .servo_ready_output(out_t[3]), .alarm_code_bit_one(out_t[4]),
    .alarm_code_bit_two(out_t[5]), .alarm_code_bit_three(out_t[6]),
    .hard_block_input_one(hb[0]), .hard_block_input_two(hb[1]),
    .panel_mode(panel_mode), .monitor_number(monitor_number), .segments(segments));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [55:0] exp, input logic [55:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // monitor 0 input, 1 output, 2 safety with inverted polarity
  function automatic logic [55:0] expect_seg(input int m, input logic [7:0] v);
    logic [55:0] s;
    int          n;
    s = 56'h0;
    n = m == 0 ? 8 : (m == 1 ? 7 : 2);
    for (int p = 0; p < n; p++) s[p * 7 + 3 * int'(v[p] ^ (m == 2))] = 1'b1;
    return s;
  endfunction
  task automatic select_steps;
    op.push(1, 6);
    check("mode", 56'h0, 56'(panel_mode));
    op.push(0, 6);
    check("mode", 56'h1, 56'(panel_mode));
    op.push(3, 5);
    check("mode", 56'h1, 56'(panel_mode));
    for (int i = 0; i < 6; i++) begin
      op.push(i < 3 ? 1 : 2, 6);
      check("number", 56'(seq[i]), 56'(monitor_number));
    end
  endtask
  task automatic scan(input int m, input logic [11:0] num, input logic [15:0] v);
    check("number", 56'(num), 56'(monitor_number));
    op.push(3, HOLD + 10);
    check("mode", 56'h2, 56'(panel_mode));
    for (int i = 0; i < 2; i++) begin
      op.set_io(v[i * 8 +: 8]);
      repeat (8) @(posedge clk);
      check("segments", expect_seg(m, v[i * 8 +: 8]), segments);
    end
    op.push(0, 6);
    check("mode", 56'h2, 56'(panel_mode));
    op.push(3, HOLD + 10);
    check("mode", 56'h1, 56'(panel_mode));
    check("number", 56'(num), 56'(monitor_number));
  endtask
  task automatic leave_monitor;
    op.push(0, 6);
    check("mode", 56'h0, 56'(panel_mode));
  endtask
  task automatic report_and_stop;
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial begin
    rst_b = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    check("reset segments", 56'h0, segments);
    rst_b <= 1'b1;
    select_steps;
    scan(0, 12'h005, 16'ha35c);
    op.push(1, 6);
    scan(1, 12'h006, 16'h2ad5);
    op.push(1, 6);
    scan(2, 12'h015, 16'h0201);
    leave_monitor;
    report_and_stop;
  end
endmodule
